// ### logic/sensor_control_pkg.sv
// package: register map, field layout and timing for the sensor control register
package sensor_control_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] SENSOR_CONTROL_ONE_ADDR  = 8'h15;
    localparam logic [7:0] SENSOR_CONTROL_ONE_RESET = 8'h00;

    // ==========================================================
    // field positions
    localparam int RESET_REQ_BIT      = 7;
    localparam int SELFTEST_AXIS_LSB  = 5;
    localparam int SELFTEST_POL_BIT   = 4;
    localparam int SPI_WIRE_MODE_BIT  = 3;

    // ==========================================================
    // field encodings
    localparam logic [1:0] SELFTEST_OFF = 2'h0;
    localparam logic [1:0] SELFTEST_X   = 2'h1;
    localparam logic [1:0] SELFTEST_Y   = 2'h2;
    localparam logic [1:0] SELFTEST_Z   = 2'h3;

    // ==========================================================
    // reset delay in slow oscillator cycles
    localparam logic [3:0] SLOW_OSC_WAIT_CYCLES = 4'ha;
    localparam real        SLOW_OSC_WAIT_US     = 312.5;
    localparam real        MCLK_PERIOD_NS       = 50.0;
    // typical delay seen in mclk cycles, for reference; the bench does not use it
    localparam int         SLOW_OSC_WAIT_MCLKS  = int'(SLOW_OSC_WAIT_US * 1000.0 / MCLK_PERIOD_NS);

    // ==========================================================
    // register contents kept by this block
    typedef struct packed {
        logic [1:0] selftest_axis_select;
        logic       selftest_polarity;
        logic       spi_wire_mode;
    } sensor_control_t;

    // bits that survive a soft reset
    typedef struct packed {
        logic irq_pin_polarity;
        logic irq_pin_drive_type;
        logic boot_disable;
    } persist_bits_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PENDING,
        ST_RUN,
        ST_BOOT
    } reset_state_t;

endpackage : sensor_control_pkg

// ### logic/sensor_control_reset_selftest.sv
// sensor control register: soft reset sequencing, self-test and spi wire mode
`timescale 1ns/1ps
`default_nettype none

// Contract
// - soft reset request on bit 7 is accepted in every operating mode.
// - irq polarity, irq drive type and boot disable survive a soft reset.
// - soft reset also resets the i2c and spi interface logic.
// - reset sequence waits for i2c stop or spi chip select release.
// - read after the write shows 0, except i2c repeated-start read shows 1.
// - reset starts no sooner than 10 slow oscillator cycles after the request.
// - self-test axis 00b off (reset), 01b x axis, 11b z axis.
// - self-test polarity 0 positive (default), 1 negative displacement.
// - wire-mode bit 0 selects 4-wire spi (default), 1 selects 3-wire.
// - wire-mode bit only matters when the interface pin selects spi.
// - 3-wire: data-in pin bidirectional, data-out pin held high impedance.
// - power-on, brown-out or hibernate exit returns to 4-wire spi.
// - spi with data lines shorted runs 3-wire whatever the wire-mode bit.
module sensor_control_reset_selftest
    import sensor_control_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // register access from the serial engine
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       rd_after_restart,
    output logic      [7:0] reg_rdata_q,
    // serial bus activity
    input  wire logic       i2c_start,
    input  wire logic       i2c_stop,
    input  wire logic       spi_cs_n,
    input  wire logic       interface_select_pin,
    input  wire logic       data_lines_tied,
    input  wire logic       spi_tx_bit,
    input  wire logic       spi_tx_drive,
    // spi data pins, output side
    output logic            spi_mosi_o_q,
    output logic            spi_mosi_oe_q,
    output logic            spi_miso_o_q,
    output logic            spi_miso_oe_q,
    output logic            spi_three_wire_q,
    // slow oscillator and power events
    input  wire logic       slow_oscillator,
    input  wire logic       brown_out,
    input  wire logic       hibernate_enter,
    input  wire logic       hibernate_exit,
    // retained bits
    input  wire logic       persist_wr,
    input  wire logic [2:0] persist_wdata,
    output persist_bits_t   persist_q,
    // reset sequencing
    output logic            func_reset_q,
    output logic            serial_reset_q,
    output logic            boot_done_q,
    // self-test drive
    output logic      [2:0] selftest_axis_en_q,
    output logic            selftest_negative_q
);

    // ==========================================================
    // pin synchronisers: cs, interface select, slow osc, tie strap
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
        end else begin
            sync1_q <= {data_lines_tied, slow_oscillator, interface_select_pin, spi_cs_n};
            sync2_q <= sync1_q;
        end
    end
    logic cs_n_s, spi_sel_s, slow_s, tied_s;
    assign cs_n_s    = sync2_q[0];
    assign spi_sel_s = sync2_q[1];
    assign slow_s    = sync2_q[2];
    assign tied_s    = sync2_q[3];

    logic slow_prev_q;
    // matches the synchroniser's reset level, so release makes no false edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) slow_prev_q <= 1'b1;
        else         slow_prev_q <= slow_s;
    end
    logic slow_rise;
    assign slow_rise = slow_s & ~slow_prev_q;

    // ==========================================================
    // i2c transaction tracking: busy from start until stop
    logic i2c_busy_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)                      i2c_busy_q <= 1'b0;
        else if (serial_reset_q)          i2c_busy_q <= 1'b0;
        else if (i2c_start && !spi_sel_s) i2c_busy_q <= 1'b1;
        else if (i2c_stop)                i2c_busy_q <= 1'b0;
    end
    logic bus_free;
    assign bus_free = spi_sel_s ? cs_n_s : ~i2c_busy_q;

    // ==========================================================
    // register write decode
    logic ctl_wr;
    assign ctl_wr = reg_wr && (reg_addr == SENSOR_CONTROL_ONE_ADDR);

    // ==========================================================
    // soft reset sequencer
    reset_state_t state_q;
    logic [3:0]   slow_cnt_q;
    logic         pending;
    assign pending = (state_q == ST_PENDING);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:    if (ctl_wr && reg_wdata[RESET_REQ_BIT]) state_q <= ST_PENDING;
                ST_PENDING: if (bus_free && slow_cnt_q == SLOW_OSC_WAIT_CYCLES) state_q <= ST_RUN;
                ST_RUN:     state_q <= ST_BOOT;
                ST_BOOT:    state_q <= ST_IDLE;
                default:    state_q <= ST_IDLE;
            endcase
        end
    end

    // counts slow edges from the request; saturates so a held bus cannot wrap it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)                                                slow_cnt_q <= 4'h0;
        else if (!pending)                                          slow_cnt_q <= 4'h0;
        else if (slow_rise && slow_cnt_q != SLOW_OSC_WAIT_CYCLES)   slow_cnt_q <= slow_cnt_q + 4'h1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            func_reset_q   <= 1'b0;
            serial_reset_q <= 1'b0;
            boot_done_q    <= 1'b0;
        end else begin
            func_reset_q   <= (state_q == ST_RUN);
            serial_reset_q <= (state_q == ST_RUN);
            boot_done_q    <= (state_q == ST_BOOT);
        end
    end

    // ==========================================================
    // register fields
    sensor_control_t ctl_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= '0;
        end else if (state_q == ST_RUN || brown_out || hibernate_exit) begin
            ctl_q <= '0;
        end else if (ctl_wr) begin
            ctl_q.selftest_axis_select <= reg_wdata[SELFTEST_AXIS_LSB +: 2];
            ctl_q.selftest_polarity    <= reg_wdata[SELFTEST_POL_BIT];
            ctl_q.spi_wire_mode        <= reg_wdata[SPI_WIRE_MODE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn)              persist_q <= '0;
        else if (hibernate_enter) persist_q <= '0;
        else if (persist_wr)      persist_q <= persist_wdata;
    end

    // ==========================================================
    // read path; the pending bit is only visible to an i2c repeated-start read
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= SENSOR_CONTROL_ONE_RESET;
        end else if (reg_rd) begin
            if (reg_addr == SENSOR_CONTROL_ONE_ADDR) begin
                reg_rdata_q <= {pending & rd_after_restart & ~spi_sel_s,
                                ctl_q.selftest_axis_select,
                                ctl_q.selftest_polarity, ctl_q.spi_wire_mode, 3'h0};
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    // ==========================================================
    // self-test drive, one enable per axis
    for (genvar a = 0; a < 3; a++) begin : g_axis
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) selftest_axis_en_q[a] <= 1'b0;
            else         selftest_axis_en_q[a] <= (ctl_q.selftest_axis_select == 2'(a + 1));
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) selftest_negative_q <= 1'b0;
        // polarity only with an axis selected
        else         selftest_negative_q <= ctl_q.selftest_polarity &&
                                            (ctl_q.selftest_axis_select != SELFTEST_OFF);
    end

    // ==========================================================
    // spi pin control
    logic three_wire;
    assign three_wire = spi_sel_s && (ctl_q.spi_wire_mode || tied_s);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            spi_three_wire_q <= 1'b0;
            spi_mosi_oe_q    <= 1'b0;
            spi_miso_oe_q    <= 1'b0;
            spi_mosi_o_q     <= 1'b0;
            spi_miso_o_q     <= 1'b0;
        end else begin
            spi_three_wire_q <= three_wire;
            // data-in pin turns round, data-out pin released
            spi_mosi_oe_q    <= three_wire && spi_tx_drive && !cs_n_s;
            spi_miso_oe_q    <= spi_sel_s && !three_wire && spi_tx_drive && !cs_n_s;
            spi_mosi_o_q     <= three_wire && spi_tx_bit;
            spi_miso_o_q     <= !three_wire && spi_tx_bit;
        end
    end

    // ==========================================================
    // assertions
    sequence s_request;
        (state_q == ST_IDLE) && ctl_wr && reg_wdata[RESET_REQ_BIT];
    endsequence
    sequence s_run_then_boot;
        func_reset_q ##1 boot_done_q;
    endsequence

    property p_request_pends;
        @(posedge mclk) disable iff (!resetn) s_request |=> pending;
    endproperty
    a_request_pends: assert property (p_request_pends) else $error("reset request not pending");

    property p_reset_boot;
        @(posedge mclk) disable iff (!resetn)
            (state_q == ST_RUN) |=> s_run_then_boot ##0 (ctl_q == '0);
    endproperty
    a_reset_boot: assert property (p_reset_boot) else $error("reset sequence wrong");

    property p_persist_kept;
        @(posedge mclk) disable iff (!resetn)
            func_reset_q && !persist_wr && !hibernate_enter |=> $stable(persist_q);
    endproperty
    a_persist_kept: assert property (p_persist_kept) else $error("retained bits lost");

    property p_serial_reset;
        @(posedge mclk) disable iff (!resetn) func_reset_q == serial_reset_q;
    endproperty
    a_serial_reset: assert property (p_serial_reset) else $error("serial reset missing");

    property p_bus_hold;
        @(posedge mclk) disable iff (!resetn) pending && !bus_free |=> !func_reset_q;
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("reset during transaction");

    property p_restart_read;
        @(posedge mclk) disable iff (!resetn)
            pending && reg_rd && rd_after_restart && !spi_sel_s &&
            reg_addr == SENSOR_CONTROL_ONE_ADDR |=> reg_rdata_q[RESET_REQ_BIT];
    endproperty
    a_restart_read: assert property (p_restart_read) else $error("restart read lost bit");

    property p_slow_delay;
        @(posedge mclk) disable iff (!resetn)
            (state_q == ST_RUN) |-> $past(slow_cnt_q) == SLOW_OSC_WAIT_CYCLES;
    endproperty
    a_slow_delay: assert property (p_slow_delay) else $error("reset started early");

    property p_axis;
        @(posedge mclk) disable iff (!resetn)
            ctl_q.selftest_axis_select == SELFTEST_Y |=> selftest_axis_en_q == 3'h2;
    endproperty
    a_axis: assert property (p_axis) else $error("axis decode wrong");

    property p_i2c_pins;
        @(posedge mclk) disable iff (!resetn)
            !spi_sel_s |=> !spi_three_wire_q && !spi_mosi_oe_q && !spi_miso_oe_q;
    endproperty
    a_i2c_pins: assert property (p_i2c_pins) else $error("spi pins active in i2c");

    property p_three_wire_miso;
        @(posedge mclk) disable iff (!resetn) spi_three_wire_q |-> !spi_miso_oe_q;
    endproperty
    a_three_wire_miso: assert property (p_three_wire_miso) else $error("miso driven");

    property p_hib_exit;
        @(posedge mclk) disable iff (!resetn)
            hibernate_exit |=> !ctl_q.spi_wire_mode;
    endproperty
    a_hib_exit: assert property (p_hib_exit) else $error("wire mode kept");

    property p_tied;
        @(posedge mclk) disable iff (!resetn) spi_sel_s && tied_s |=> spi_three_wire_q;
    endproperty
    a_tied: assert property (p_tied) else $error("tied lines not 3-wire");

endmodule : sensor_control_reset_selftest

`default_nettype wire

// ### verification/host_link_model.sv
// host side model: free-running slow oscillator and spi chip select
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // clock
    input  wire logic mclk,
    // frame request from the bench
    input  wire logic frame_open,
    // pins toward the block
    output logic      spi_cs_n,
    output logic      slow_oscillator
);
    // ==========================================================
    // slow oscillator, 400 ns period, phase unrelated to mclk
    initial begin
        slow_oscillator = 1'b0;
        #137;
        forever #200 slow_oscillator = ~slow_oscillator;
    end

    // ==========================================================
    // chip select moves just after an edge and stands for the frame
    initial begin
        spi_cs_n = 1'b1;
        forever @(posedge mclk) spi_cs_n <= ~frame_open;
    end
endmodule : host_link_model
`default_nettype wire

// ### verification/tb_sensor_control_reset_selftest.sv
// self-checking bench for the sensor control register block
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_control_reset_selftest;
    import sensor_control_pkg::*;
    logic          mclk, resetn, reg_wr, reg_rd, rd_after_restart, i2c_start, i2c_stop;
    logic          spi_cs_n, interface_select_pin, data_lines_tied, spi_tx_bit, spi_tx_drive;
    logic          spi_mosi_o_q, spi_mosi_oe_q, spi_miso_o_q, spi_miso_oe_q, spi_three_wire_q;
    logic          slow_oscillator, brown_out, hibernate_enter, hibernate_exit, persist_wr;
    logic          func_reset_q, serial_reset_q, boot_done_q, selftest_negative_q, frame_open;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata_q, d, wd;
    logic [2:0]    persist_wdata, selftest_axis_en_q, ea;
    persist_bits_t persist_q;
    int            error_cnt, n_compared, rst_pulses, slow_edges, p0, s0, s1, cyc;
    logic          ex;

    sensor_control_reset_selftest dut (.mclk, .resetn, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .rd_after_restart, .reg_rdata_q, .i2c_start, .i2c_stop, .spi_cs_n,
        .interface_select_pin, .data_lines_tied, .spi_tx_bit, .spi_tx_drive, .spi_mosi_o_q,
        .spi_mosi_oe_q, .spi_miso_o_q, .spi_miso_oe_q, .spi_three_wire_q, .slow_oscillator,
        .brown_out, .hibernate_enter, .hibernate_exit, .persist_wr, .persist_wdata,
        .persist_q, .func_reset_q, .serial_reset_q, .boot_done_q, .selftest_axis_en_q,
        .selftest_negative_q);
    host_link_model host (.mclk, .frame_open, .spi_cs_n, .slow_oscillator);

    // ==========================================================
    // clock and monitors
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // slow edge count latched at the reset pulse itself
    always @(posedge mclk) if (func_reset_q === 1'b1) begin
        rst_pulses++;
        s1 = slow_edges;
    end
    always @(posedge slow_oscillator) slow_edges++;

    // ==========================================================
    // access tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic rs, output logic [7:0] q);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_after_restart <= rs;
        @(posedge mclk);
        reg_rd <= 1'b0;
        rd_after_restart <= 1'b0;
        @(posedge mclk);
        #1 q = reg_rdata_q;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    // waits for the reset pulse, then checks what a finished reset leaves behind
    task automatic wait_reset(input int lim);
        cyc = 0;
        while (func_reset_q !== 1'b1 && cyc < lim) begin
            settle(1);
            cyc++;
        end
        if (cyc >= lim) begin
            $display("[FAIL] func_reset_q expected 1 seen %b", func_reset_q);
            error_cnt++;
            return;
        end
        chk("serial reset", 8'h1, {7'h0, serial_reset_q});
        settle(1);
        chk("boot done", 8'h1, {7'h0, boot_done_q});
        rd(8'h15, 1'b0, d);
        chk("fields after reset", SENSOR_CONTROL_ONE_RESET, d);
        chk("retained bits", 8'h05, {5'h0, persist_q});
    endtask : wait_reset

    // ==========================================================
    // main sequence
    initial begin
        {resetn, reg_wr, reg_rd, rd_after_restart, i2c_start, i2c_stop} = '0;
        {data_lines_tied, spi_tx_bit, spi_tx_drive, brown_out, frame_open} = '0;
        {hibernate_enter, hibernate_exit, persist_wr, persist_wdata} = '0;
        {reg_addr, reg_wdata, error_cnt, n_compared, rst_pulses, slow_edges} = '0;
        interface_select_pin = 1'b1;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        settle(4);
        rd(8'h15, 1'b0, d);
        chk("reset value", SENSOR_CONTROL_ONE_RESET, d);
        wr(8'h3c, 8'hff);
        rd(8'h3c, 1'b0, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            wd = {1'b0, i[2:1], i[0], 4'h0};
            ea = (i[2:1] == 2'h0) ? 3'h0 : 3'h1 << (i[2:1] - 2'h1);
            wr(8'h15, wd);
            settle(3);
            chk("axis enables", {5'h0, ea}, {5'h0, selftest_axis_en_q});
            chk("negative drive", {7'h0, i[0] & (ea != 3'h0)}, {7'h0, selftest_negative_q});
            rd(8'h15, 1'b0, d);
            chk("self-test readback", wd, d);
        end
        $display("test self-test fields done");
        for (int j = 0; j < 8; j++) begin
            ex = j[2] & (j[1] | j[0]);
            interface_select_pin <= j[2];
            data_lines_tied <= j[1];
            wr(8'h15, {4'h0, j[0], 3'h0});
            frame_open <= 1'b1;
            spi_tx_drive <= 1'b1;
            spi_tx_bit <= 1'b1;
            settle(6);
            chk("three wire mode", {7'h0, ex}, {7'h0, spi_three_wire_q});
            if (j[2]) chk("pin enables", {6'h0, ex, ~ex}, {6'h0, spi_mosi_oe_q, spi_miso_oe_q});
            if (j[2]) chk("pin data", {6'h0, ex, ~ex}, {6'h0, spi_mosi_o_q, spi_miso_o_q});
            frame_open <= 1'b0;
            spi_tx_drive <= 1'b0;
            spi_tx_bit <= 1'b0;
        end
        data_lines_tied <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            wr(8'h15, 8'h08);
            @(posedge mclk);
            if (k == 0) brown_out <= 1'b1;
            else hibernate_exit <= 1'b1;
            @(posedge mclk);
            {brown_out, hibernate_exit} <= 2'b00;
            settle(3);
            chk("four wire after event", 8'h0, {7'h0, spi_three_wire_q});
        end
        $display("test wire mode done");
        @(posedge mclk);
        persist_wr <= 1'b1;
        persist_wdata <= 3'h5;
        @(posedge mclk);
        persist_wr <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            interface_select_pin <= (k == 0);
            settle(6);
            // bus kept busy by an open spi frame or an i2c start
            if (k == 0) frame_open <= 1'b1;
            else i2c_start <= 1'b1;
            @(posedge mclk);
            i2c_start <= 1'b0;
            settle(4);
            wr(8'h15, 8'ha8);
            rd(8'h15, 1'b1, d);
            chk("restart read bit", {7'h0, k == 1}, {7'h0, d[7]});
            rd(8'h15, 1'b0, d);
            chk("plain read bit", 8'h0, {7'h0, d[7]});
            p0 = rst_pulses;
            settle(140);
            chk("reset held while busy", p0[7:0], rst_pulses[7:0]);
            if (k == 0) frame_open <= 1'b0;
            else i2c_stop <= 1'b1;
            @(posedge mclk);
            i2c_stop <= 1'b0;
            wait_reset(20);
        end
        $display("test held reset done");
        interface_select_pin <= 1'b1;
        settle(6);
        s0 = slow_edges;
        wr(8'h15, 8'h80);
        wait_reset(1000);
        chk("slow edges waited", 8'h1, {7'h0, (s1 - s0) inside {[10:11]}});
        @(posedge mclk);
        hibernate_enter <= 1'b1;
        @(posedge mclk);
        hibernate_enter <= 1'b0;
        settle(1);
        chk("retained after hibernate", 8'h00, {5'h0, persist_q});
        $display("test reset delay done");
        wr(8'h15, 8'h78);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        settle(4);
        rd(8'h15, 1'b0, d);
        chk("fields after power reset", 8'h00, d);
        chk("four wire after power reset", 8'h0, {7'h0, spi_three_wire_q});
        $display("test power reset done");
        tally_and_finish();
    end
endmodule : tb_sensor_control_reset_selftest
`default_nettype wire
